// File: rba_pkg.sv
`default_nettype none
package rba_pkg;

  // register table addresses
  localparam logic [15:0] ADDR_MODE_CFG   = 16'h0045;
  localparam logic [15:0] ADDR_COMM_TMO   = 16'h008C;
  localparam logic [15:0] ADDR_FS_BRIGHT  = 16'h008D;
  localparam logic [15:0] ADDR_REV_TMO    = 16'h00E2;
  localparam logic [15:0] ADDR_PORT_ORDER = 16'h0001;
  localparam logic [15:0] ADDR_BAUD_SEL   = 16'h0002;
  localparam logic [15:0] ADDR_SLAVE_ID   = 16'h0003;
  localparam logic [15:0] ADDR_STATUS     = 16'h0004;

  // remote_mode_config fields
  localparam int CFG_RUN_ORDER_BIT = 0;
  localparam int CFG_PREF_B1_BIT   = 1;
  localparam int CFG_REVERSE_BIT   = 3;
  localparam int CFG_FAILSAFE_BIT  = 5;

  // port order word: run flag and level
  localparam int ORDER_RUN_BIT = 8;

  // status word fields
  localparam int STS_RUN_BIT  = 8;
  localparam int STS_LOSS_BIT = 9;
  localparam int STS_SRC_LSB  = 12;

  // reset values and limits
  localparam logic [7:0]  MODE_CFG_RST  = 8'h00;
  localparam logic [15:0] COMM_TMO_RST  = 16'h00FA;
  localparam logic [15:0] FS_BRIGHT_RST = 16'h0003;
  localparam logic [15:0] REV_TMO_RST   = 16'h00FA;
  localparam logic [15:0] ORDER_RST     = 16'h0000;
  localparam logic [1:0]  BAUD_RST      = 2'h2;
  localparam logic [7:0]  SLAVE_ID_RST  = 8'h01;
  localparam logic [7:0]  SLAVE_ID_MIN  = 8'h01;
  localparam logic [7:0]  SLAVE_ID_MAX  = 8'hF9;
  localparam logic [15:0] FS_BRIGHT_MAX = 16'h0007;
  localparam logic [15:0] CNT_SAT       = 16'hFFFF;

  // baud codes 0..3: 2400, 4800, 9600, 19200
  localparam logic [1:0] BAUD_2400  = 2'h0;
  localparam logic [1:0] BAUD_19200 = 2'h3;

  // command functions, quantity limits and exceptions
  localparam logic [7:0] FN_READ_WORDS  = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE   = 8'h06;
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] READ_QTY_MIN   = 8'h01;
  localparam logic [7:0] READ_QTY_MAX   = 8'h64;
  localparam logic [7:0] MULTI_QTY      = 8'h01;
  localparam logic [7:0] EXC_NONE       = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC   = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR   = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE  = 8'h03;

  localparam logic [15:0] NET_TCP_PORT = 16'h01F6;
  localparam logic [1:0]  MAX_SOCKETS  = 2'h2;

  // timing
  localparam int CLK_KHZ       = 250000;
  localparam int STOP_DELAY_MS = 200;
  localparam int TICK_MS       = 20;
  localparam int STOP_DELAY_CYC = STOP_DELAY_MS * CLK_KHZ;
  localparam int TICK_CYC       = TICK_MS * CLK_KHZ;

  typedef enum logic [3:0] {
    SRC_NONE     = 4'b0001,
    SRC_WIRE     = 4'b0010,
    SRC_PORT     = 4'b0100,
    SRC_FAILSAFE = 4'b1000
  } rba_src_e;

endpackage
`default_nettype wire

// File: rba_cmd_check.sv
`timescale 1ns/1ps
`default_nettype none
// decodes one port request: address match, function, quantity, table address
module rba_cmd_check
  import rba_pkg::*;
(
  input  wire logic       valid,
  input  wire logic [7:0] unit,
  input  wire logic [7:0] func,
  input  wire logic [15:0] addr,
  input  wire logic [7:0] qty,
  input  wire logic [7:0] slave_id,
  output logic            for_us,
  output logic            is_read,
  output logic            is_write,
  output logic [7:0]      exc
);

  logic known;

  always_comb begin
    known = (addr == ADDR_MODE_CFG) || (addr == ADDR_COMM_TMO) || (addr == ADDR_FS_BRIGHT) ||
            (addr == ADDR_REV_TMO) || (addr == ADDR_PORT_ORDER) || (addr == ADDR_BAUD_SEL) ||
            (addr == ADDR_SLAVE_ID) || (addr == ADDR_STATUS);
    for_us   = valid && (unit == slave_id);
    is_read  = 1'b0;
    is_write = 1'b0;
    exc      = EXC_NONE;
    unique case (func)
      FN_READ_WORDS: begin
        if (qty < READ_QTY_MIN || qty > READ_QTY_MAX) exc = EXC_BAD_VALUE;
        else if (!known) exc = EXC_BAD_ADDR;
        else is_read = for_us;
      end
      FN_WRITE_ONE: begin
        if (!known) exc = EXC_BAD_ADDR;
        else is_write = for_us;
      end
      FN_WRITE_MULTI: begin
        if (qty != MULTI_QTY) exc = EXC_BAD_VALUE;
        else if (!known) exc = EXC_BAD_ADDR;
        else is_write = for_us;
      end
      default: exc = EXC_BAD_FUNC;
    endcase
  end

endmodule
`default_nettype wire

// File: rba_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - config bit 0 picks direct or run-order wire mode; bit 1 picks preferred level
// - direct mode: any brightness input starts regulator at the highest active input's level
// - direct mode: stop 0.2 s after the last brightness input drops
// - run-order mode: run input alone starts at the preferred level
// - run-order mode: an added brightness input changes the level
// - run-order mode: releasing run stops at once, whatever the brightness inputs
// - preferred level resets to level zero
// - serial ports default to 9600 baud, slave id 1
// - baud from 2400 to 19200 in four steps, slave id 1 to 249
// - new baud or slave id applies only after a device reset
// - both ports share the table; the latest order wins, port 1's on a same-cycle pair
// - functions 3 (up to 100 words), 6 and 16 (one word); tcp port 502
// - each network interface accepts at most two clients
// - config bit 5 enables fail-safe level on comm loss or wire break
// - comm-loss timeout in 20 ms units, default 250
// - fail-safe level 0..7, 0 stops, default 3
// - standard priority: wires win, ports apply only while wires order stop
// - reverse priority: ports win until no request within the reverse timeout
// - config bit 3 picks standard or reverse priority, standard by default
module rba_arbiter
  import rba_pkg::*;
#(
  parameter int STOP_CYC = STOP_DELAY_CYC,
  parameter int TICK_LEN = TICK_CYC,
  parameter int NLEV     = 8
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             por_n,
  input  wire logic [NLEV-1:0]  bright_in,
  input  wire logic             run_in,
  input  wire logic             wire_link_ok,
  input  wire logic [1:0]       cmd_valid,
  input  wire logic [1:0][7:0]  cmd_unit,
  input  wire logic [1:0][7:0]  cmd_func,
  input  wire logic [1:0][15:0] cmd_addr,
  input  wire logic [1:0][7:0]  cmd_qty,
  input  wire logic [1:0][15:0] cmd_wdata,
  output logic [1:0]            rsp_valid,
  output logic [1:0][7:0]       rsp_exc,
  output logic [1:0][15:0]      rsp_data,
  input  wire logic [1:0]       sock_open,
  input  wire logic [1:0]       sock_close,
  output logic [1:0]            sock_grant,
  output logic [1:0]            sock_refuse,
  output logic [1:0]            baud_sel,
  output logic [7:0]            slave_id,
  output logic [15:0]           tcp_port,
  output logic                  current_regulator_run,
  output logic [2:0]            current_regulator_level,
  output logic                  comm_loss
);

  logic [7:0]       cfg_q;
  logic [15:0]      comm_tmo_q, fs_q, rev_tmo_q, order_q;
  logic [1:0]       baud_store_q, baud_q;
  logic [7:0]       id_store_q, id_q;
  logic             wire_run_q;
  logic [2:0]       wire_lvl_q;
  logic [31:0]      dly_q;
  logic [31:0]      tick_q;
  logic [15:0]      since_q;
  logic             out_run_q;
  logic [2:0]       out_lvl_q;
  rba_src_e         src_q, src_d;
  logic [1:0]       vrsp_q;
  logic [1:0][7:0]  exc_q;
  logic [1:0][15:0] data_q;
  logic [1:0][1:0]  sock_cnt_q;
  logic [1:0]       grant_q, refuse_q;
  logic [1:0]       for_us, is_rd, is_wr;
  logic [1:0][7:0]  chk_exc, exc_d;
  logic             any_in, tick, loss, port_fresh, fs_cond, run_d;
  logic [2:0]       hi_lvl, lvl_d;

  function automatic logic val_ok(input logic [15:0] a, input logic [15:0] v);
    val_ok = 1'b1;
    if (a == ADDR_FS_BRIGHT) val_ok = (v <= FS_BRIGHT_MAX);
    if (a == ADDR_BAUD_SEL) val_ok = (v[1:0] >= BAUD_2400) && (v[1:0] <= BAUD_19200) && (v[15:2] == '0);
    if (a == ADDR_SLAVE_ID) val_ok = (v >= {8'h00, SLAVE_ID_MIN}) && (v <= {8'h00, SLAVE_ID_MAX});
    if (a == ADDR_STATUS) val_ok = 1'b0;
  endfunction

  function automatic logic [15:0] rd_word(input logic [15:0] a);
    rd_word = '0;
    unique case (a)
      ADDR_MODE_CFG:   rd_word = {8'h00, cfg_q};
      ADDR_COMM_TMO:   rd_word = comm_tmo_q;
      ADDR_FS_BRIGHT:  rd_word = fs_q;
      ADDR_REV_TMO:    rd_word = rev_tmo_q;
      ADDR_PORT_ORDER: rd_word = order_q;
      ADDR_BAUD_SEL:   rd_word = {14'h0000, baud_store_q};
      ADDR_SLAVE_ID:   rd_word = {8'h00, id_store_q};
      ADDR_STATUS: begin
        rd_word[2:0] = out_lvl_q;
        rd_word[STS_RUN_BIT] = out_run_q;
        rd_word[STS_LOSS_BIT] = loss;
        rd_word[STS_SRC_LSB +: 4] = src_q;
      end
      default: rd_word = '0;
    endcase
  endfunction

  for (genvar p = 0; p < 2; p++) begin : g_chk
    rba_cmd_check u_chk (
      .valid    (cmd_valid[p]),
      .unit     (cmd_unit[p]),
      .func     (cmd_func[p]),
      .addr     (cmd_addr[p]),
      .qty      (cmd_qty[p]),
      .slave_id (id_q),
      .for_us   (for_us[p]),
      .is_read  (is_rd[p]),
      .is_write (is_wr[p]),
      .exc      (chk_exc[p])
    );
    assign exc_d[p] = (chk_exc[p] != EXC_NONE) ? chk_exc[p] :
                      (is_wr[p] && !val_ok(cmd_addr[p], cmd_wdata[p])) ? EXC_BAD_VALUE : EXC_NONE;
  end

  always_comb begin
    hi_lvl = '0;
    for (int i = 0; i < NLEV; i++) begin
      if (bright_in[i]) hi_lvl = 3'(i);
    end
    any_in = |bright_in;
  end

  // table writes; port 1 is taken after port 0 so a same-cycle pair keeps port 1's word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q      <= MODE_CFG_RST;
      comm_tmo_q <= COMM_TMO_RST;
      fs_q       <= FS_BRIGHT_RST;
      rev_tmo_q  <= REV_TMO_RST;
      order_q    <= ORDER_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (is_wr[p] && exc_d[p] == EXC_NONE) begin
          unique case (cmd_addr[p])
            ADDR_MODE_CFG:   cfg_q <= cmd_wdata[p][7:0];
            ADDR_COMM_TMO:   comm_tmo_q <= cmd_wdata[p];
            ADDR_FS_BRIGHT:  fs_q <= cmd_wdata[p];
            ADDR_REV_TMO:    rev_tmo_q <= cmd_wdata[p];
            ADDR_PORT_ORDER: order_q <= cmd_wdata[p];
            default: ;
          endcase
        end
      end
    end
  end

  // stored serial settings survive device reset; only power-on clears them
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      baud_store_q <= BAUD_RST;
      id_store_q   <= SLAVE_ID_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (is_wr[p] && exc_d[p] == EXC_NONE && cmd_addr[p] == ADDR_BAUD_SEL) baud_store_q <= cmd_wdata[p][1:0];
        if (is_wr[p] && exc_d[p] == EXC_NONE && cmd_addr[p] == ADDR_SLAVE_ID) id_store_q <= cmd_wdata[p][7:0];
      end
    end
  end

  // active settings follow the stored ones only while device reset is held
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      baud_q <= BAUD_RST;
      id_q   <= SLAVE_ID_RST;
    end else if (!rst_n) begin
      baud_q <= baud_store_q;
      id_q   <= id_store_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vrsp_q <= '0;
      exc_q  <= '0;
      data_q <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        vrsp_q[p] <= for_us[p];
        exc_q[p]  <= exc_d[p];
        data_q[p] <= is_rd[p] ? rd_word(cmd_addr[p]) : cmd_wdata[p];
      end
    end
  end

  // client sockets per network interface
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sock_cnt_q <= '0;
      grant_q    <= '0;
      refuse_q   <= '0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        grant_q[n]  <= sock_open[n] && (sock_cnt_q[n] < MAX_SOCKETS || sock_close[n]);
        refuse_q[n] <= sock_open[n] && sock_cnt_q[n] >= MAX_SOCKETS && !sock_close[n];
        if (sock_open[n] && !sock_close[n] && sock_cnt_q[n] < MAX_SOCKETS) sock_cnt_q[n] <= sock_cnt_q[n] + 2'h1;
        else if (sock_close[n] && !sock_open[n] && sock_cnt_q[n] != 2'h0) sock_cnt_q[n] <= sock_cnt_q[n] - 2'h1;
      end
    end
  end

  // wire control
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wire_run_q <= 1'b0;
      wire_lvl_q <= '0;
      dly_q      <= '0;
    end else if (cfg_q[CFG_RUN_ORDER_BIT]) begin
      dly_q      <= '0;
      wire_run_q <= run_in;
      wire_lvl_q <= any_in ? hi_lvl : {2'b00, cfg_q[CFG_PREF_B1_BIT]};
    end else if (any_in) begin
      dly_q      <= '0;
      wire_run_q <= 1'b1;
      wire_lvl_q <= hi_lvl;
    end else if (wire_run_q) begin
      dly_q <= dly_q + 32'd1;
      if (dly_q == 32'(STOP_CYC - 1)) wire_run_q <= 1'b0;
    end
  end

  // 20 ms ticks since the last request addressed to this device
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_q  <= '0;
      since_q <= CNT_SAT;
    end else if (|for_us) begin
      tick_q  <= '0;
      since_q <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + 32'd1;
      if (tick && since_q != CNT_SAT) since_q <= since_q + 16'h0001;
    end
  end

  always_comb begin
    tick       = (tick_q == 32'(TICK_LEN - 1));
    loss       = (comm_tmo_q != '0) && (since_q >= comm_tmo_q);
    port_fresh = since_q < rev_tmo_q;
    fs_cond    = cfg_q[CFG_FAILSAFE_BIT] && (loss || !wire_link_ok);
    src_d      = SRC_WIRE;
    run_d      = wire_run_q;
    lvl_d      = wire_lvl_q;
    if (fs_cond) begin
      src_d = SRC_FAILSAFE;
      run_d = (fs_q != '0);
      lvl_d = fs_q[2:0];
    end else if (cfg_q[CFG_REVERSE_BIT] ? port_fresh : !wire_run_q) begin
      src_d = SRC_PORT;
      run_d = order_q[ORDER_RUN_BIT];
      lvl_d = order_q[2:0];
    end
    if (!run_d) src_d = SRC_NONE;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_run_q <= 1'b0;
      out_lvl_q <= '0;
      src_q     <= SRC_NONE;
    end else begin
      out_run_q <= run_d;
      out_lvl_q <= lvl_d;
      src_q     <= src_d;
    end
  end

  assign rsp_valid               = vrsp_q;
  assign rsp_exc                 = exc_q;
  assign rsp_data                = data_q;
  assign sock_grant              = grant_q;
  assign sock_refuse             = refuse_q;
  assign baud_sel                = baud_q;
  assign slave_id                = id_q;
  assign tcp_port                = NET_TCP_PORT;
  assign current_regulator_run   = out_run_q;
  assign current_regulator_level = out_lvl_q;
  assign comm_loss               = loss;

  chk_direct_start: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q[CFG_RUN_ORDER_BIT] && any_in |=> wire_run_q && wire_lvl_q == $past(hi_lvl))
    else $error("direct input did not start at its level");
  chk_stop_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(wire_run_q) && !$past(cfg_q[CFG_RUN_ORDER_BIT]) |-> $past(dly_q) == 32'(STOP_CYC - 1))
    else $error("direct stop not after the stop delay");
  chk_order_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q[CFG_RUN_ORDER_BIT] && !run_in |=> !wire_run_q)
    else $error("run release did not stop");
  chk_order_pref: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q[CFG_RUN_ORDER_BIT] && run_in && !any_in |=> wire_lvl_q == {2'b00, $past(cfg_q[CFG_PREF_B1_BIT])})
    else $error("run without level not at preferred level");
  chk_last_order: assert property (@(posedge mclk) disable iff (!rst_n)
    &is_wr && cmd_addr[0] == ADDR_PORT_ORDER && cmd_addr[1] == ADDR_PORT_ORDER && exc_d == '0
    |=> order_q == $past(cmd_wdata[1]))
    else $error("same-cycle order pair not resolved to port 1");
  chk_sock_limit: assert property (@(posedge mclk) disable iff (!rst_n)
    sock_open[0] && !sock_close[0] && sock_cnt_q[0] == MAX_SOCKETS |=> sock_refuse[0] && !sock_grant[0] ##1 sock_cnt_q[0] == MAX_SOCKETS)
    else $error("third client accepted");
  chk_failsafe_out: assert property (@(posedge mclk) disable iff (!rst_n)
    fs_cond |=> current_regulator_level == $past(fs_q[2:0]) && current_regulator_run == ($past(fs_q) != '0))
    else $error("fail-safe level not driven");
  chk_wire_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    !fs_cond && !cfg_q[CFG_REVERSE_BIT] && wire_run_q |=> current_regulator_run && current_regulator_level == $past(wire_lvl_q))
    else $error("port overrode wire under standard priority");
  chk_multi_qty: assert property (@(posedge mclk) disable iff (!rst_n)
    for_us[0] && cmd_func[0] == FN_WRITE_MULTI && cmd_qty[0] != MULTI_QTY |=> rsp_valid[0] && rsp_exc[0] == EXC_BAD_VALUE)
    else $error("multi-word write not refused");

endmodule
`default_nettype wire

// File: rba_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module rba_master_model
  import rba_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic [1:0]       rsp_valid,
  input  wire logic [1:0][7:0]  rsp_exc,
  input  wire logic [1:0][15:0] rsp_data,
  input  wire logic [1:0]       sock_grant,
  input  wire logic [1:0]       sock_refuse,
  output logic [1:0]            cmd_valid,
  output logic [1:0][7:0]       cmd_unit,
  output logic [1:0][7:0]       cmd_func,
  output logic [1:0][15:0]      cmd_addr,
  output logic [1:0][7:0]       cmd_qty,
  output logic [1:0][15:0]      cmd_wdata,
  output logic [7:0]            bright_in,
  output logic                  run_in,
  output logic                  wire_link_ok,
  output logic [1:0]            sock_open,
  output logic [1:0]            sock_close
);
  initial begin
    cmd_valid = 2'h0;
    cmd_unit = '0;
    cmd_func = '0;
    cmd_addr = '0;
    cmd_qty = '0;
    cmd_wdata = '0;
    bright_in = 8'h00;
    run_in = 1'b0;
    wire_link_ok = 1'b1;
    sock_open = 2'h0;
    sock_close = 2'h0;
  end

  // one request per selected port, held over the taking edge
  task automatic req(input logic [1:0] pm, input logic [7:0] un, input logic [7:0] fn, input logic [15:0] ad,
                     input logic [7:0] qt, input logic [15:0] w0, input logic [15:0] w1,
                     output logic [1:0] rv, output logic [1:0][7:0] ex, output logic [1:0][15:0] rd);
    @(negedge mclk);
    for (int p = 0; p < 2; p++) begin
      cmd_unit[p] = un;
      cmd_func[p] = fn;
      cmd_addr[p] = ad;
      cmd_qty[p] = qt;
    end
    cmd_wdata[0] = w0;
    cmd_wdata[1] = w1;
    cmd_valid = pm;
    @(posedge mclk);
    @(negedge mclk);
    rv = rsp_valid;
    ex = rsp_exc;
    rd = rsp_data;
    cmd_valid = 2'h0;
    // released fields flip so stale values cannot pass
    cmd_unit = ~cmd_unit;
    cmd_func = ~cmd_func;
    cmd_addr = ~cmd_addr;
    cmd_qty = ~cmd_qty;
    cmd_wdata = ~cmd_wdata;
  endtask

  task automatic wires(input logic [7:0] b, input logic r, input logic l);
    @(negedge mclk);
    bright_in = b;
    run_in = r;
    wire_link_ok = l;
  endtask

  task automatic sockop(input int n, input logic o, input logic c, output logic g, output logic rf);
    @(negedge mclk);
    sock_open[n] = o;
    sock_close[n] = c;
    @(posedge mclk);
    @(negedge mclk);
    g = sock_grant[n];
    rf = sock_refuse[n];
    sock_open[n] = 1'b0;
    sock_close[n] = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rba_pkg::*;
  localparam int STOP_N = 20;
  localparam int TICK_N = 4;
  logic mclk, rst_n, por_n, run_in, wire_link_ok, crr, cl, g, rf;
  logic [7:0] bright_in, slave_id;
  logic [1:0] cmd_valid, rsp_valid, sock_open, sock_close, sock_grant, sock_refuse, baud_sel, rv;
  logic [1:0][7:0] cmd_unit, cmd_func, cmd_qty, rsp_exc, ex;
  logic [1:0][15:0] cmd_addr, cmd_wdata, rsp_data, rd;
  logic [15:0] tcp_port;
  logic [2:0] crl;
  logic [15:0] ra [4];
  logic [15:0] rx [4];
  logic [7:0] t_fn [9];
  logic [15:0] t_ad [9];
  logic [7:0] t_qt [9];
  logic [15:0] t_wd [9];
  logic [7:0] t_ex [9];
  int fail_count;
  int n_tests;

  rba_arbiter #(.STOP_CYC(STOP_N), .TICK_LEN(TICK_N), .NLEV(8)) rba_arbiter_inst (
    .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .bright_in(bright_in), .run_in(run_in),
    .wire_link_ok(wire_link_ok), .cmd_valid(cmd_valid), .cmd_unit(cmd_unit), .cmd_func(cmd_func),
    .cmd_addr(cmd_addr), .cmd_qty(cmd_qty), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
    .rsp_data(rsp_data), .sock_open(sock_open), .sock_close(sock_close), .sock_grant(sock_grant),
    .sock_refuse(sock_refuse), .baud_sel(baud_sel), .slave_id(slave_id), .tcp_port(tcp_port),
    .current_regulator_run(crr), .current_regulator_level(crl), .comm_loss(cl));

  rba_master_model rba_master_model_inst (
    .mclk(mclk), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data), .sock_grant(sock_grant),
    .sock_refuse(sock_refuse), .cmd_valid(cmd_valid), .cmd_unit(cmd_unit), .cmd_func(cmd_func),
    .cmd_addr(cmd_addr), .cmd_qty(cmd_qty), .cmd_wdata(cmd_wdata), .bright_in(bright_in), .run_in(run_in),
    .wire_link_ok(wire_link_ok), .sock_open(sock_open), .sock_close(sock_close));

  always #2 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic outs(input logic r, input logic [2:0] l);
    check({15'h0, crr}, {15'h0, r});
    if (r) check({13'h0, crl}, {13'h0, l});
  endtask

  task automatic acc(input logic [1:0] pm, input logic [7:0] fn, input logic [15:0] ad, input logic [7:0] qt,
                     input logic [15:0] w0, input logic [15:0] w1, input logic [7:0] xe, input logic [15:0] ed);
    rba_master_model_inst.req(pm, 8'h01, fn, ad, qt, w0, w1, rv, ex, rd);
    for (int p = 0; p < 2; p++) begin
      if (pm[p]) begin
        check({15'h0, rv[p]}, 16'h0001);
        check({8'h0, ex[p]}, {8'h0, xe});
        if (xe == EXC_NONE) check(rd[p], (fn == FN_READ_WORDS) ? ed : (p == 1 ? w1 : w0));
      end
    end
  endtask

  task automatic wr(input logic [1:0] pm, input logic [15:0] ad, input logic [15:0] w0, input logic [15:0] w1,
                    input logic [7:0] xe);
    acc(pm, FN_WRITE_ONE, ad, 8'h01, w0, w1, xe, 16'h0000);
  endtask

  task automatic do_reset(input logic por);
    @(negedge mclk);
    rst_n = 1'b0;
    por_n = ~por;
    cyc(5);
    rst_n = 1'b1;
    por_n = 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results;
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    por_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    ra = '{ADDR_MODE_CFG, ADDR_COMM_TMO, ADDR_FS_BRIGHT, ADDR_REV_TMO};
    rx = '{16'h0000, 16'h00FA, 16'h0003, 16'h00FA};
    t_fn = '{8'h05, 8'h03, 8'h03, 8'h03, 8'h10, 8'h03, 8'h10, 8'h06, 8'h06};
    t_ad = '{16'h0045, 16'h0045, 16'h0045, 16'h0045, 16'h008D, 16'h0050, 16'h008D, 16'h008D, 16'h0004};
    t_qt = '{8'h01, 8'h00, 8'h65, 8'h64, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
    t_wd = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0007, 16'h0000, 16'h0007, 16'h0008, 16'h0001};
    t_ex = '{8'h01, 8'h03, 8'h03, 8'h00, 8'h03, 8'h02, 8'h00, 8'h03, 8'h03};
    cyc(6);
    rst_n = 1'b1;
    por_n = 1'b1;
    for (int i = 0; i < 4; i++) acc(2'h1, FN_READ_WORDS, ra[i], 8'h01, 16'h0, 16'h0, EXC_NONE, rx[i]);
    check({14'h0, baud_sel}, 16'h0002);
    check({8'h0, slave_id}, 16'h0001);
    check(tcp_port, 16'h01F6);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) acc(2'h3, t_fn[i], t_ad[i], t_qt[i], t_wd[i], t_wd[i], t_ex[i], 16'h0000);
    acc(2'h1, FN_READ_WORDS, ADDR_FS_BRIGHT, 8'h01, 16'h0, 16'h0, EXC_NONE, 16'h0007);
    rba_master_model_inst.req(2'h1, 8'h02, FN_READ_WORDS, ADDR_MODE_CFG, 8'h01, 16'h0, 16'h0, rv, ex, rd);
    check({14'h0, rv}, 16'h0000);
    $display("test requests done");
    rba_master_model_inst.wires(8'h24, 1'b0, 1'b1);
    cyc(3);
    outs(1'b1, 3'h5);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b1);
    cyc(STOP_N - 2);
    outs(1'b1, 3'h5);
    cyc(8);
    outs(1'b0, 3'h0);
    $display("test direct mode done");
    wr(2'h1, ADDR_MODE_CFG, 16'h0001, 16'h0, EXC_NONE);
    rba_master_model_inst.wires(8'h00, 1'b1, 1'b1);
    cyc(3);
    outs(1'b1, 3'h0);
    rba_master_model_inst.wires(8'h08, 1'b1, 1'b1);
    cyc(3);
    outs(1'b1, 3'h3);
    rba_master_model_inst.wires(8'h08, 1'b0, 1'b1);
    cyc(3);
    outs(1'b0, 3'h0);
    wr(2'h1, ADDR_MODE_CFG, 16'h0003, 16'h0, EXC_NONE);
    rba_master_model_inst.wires(8'h00, 1'b1, 1'b1);
    cyc(3);
    outs(1'b1, 3'h1);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b1);
    wr(2'h1, ADDR_MODE_CFG, 16'h0000, 16'h0, EXC_NONE);
    cyc(STOP_N + 5);
    $display("test run order done");
    wr(2'h1, ADDR_PORT_ORDER, 16'h0104, 16'h0, EXC_NONE);
    cyc(2);
    outs(1'b1, 3'h4);
    wr(2'h2, ADDR_PORT_ORDER, 16'h0, 16'h0106, EXC_NONE);
    cyc(2);
    outs(1'b1, 3'h6);
    wr(2'h3, ADDR_PORT_ORDER, 16'h0102, 16'h0107, EXC_NONE);
    cyc(2);
    outs(1'b1, 3'h7);
    rba_master_model_inst.wires(8'h02, 1'b0, 1'b1);
    cyc(3);
    outs(1'b1, 3'h1);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b1);
    cyc(STOP_N + 5);
    outs(1'b1, 3'h7);
    $display("test standard priority done");
    wr(2'h1, ADDR_REV_TMO, 16'h0002, 16'h0, EXC_NONE);
    wr(2'h1, ADDR_MODE_CFG, 16'h0008, 16'h0, EXC_NONE);
    rba_master_model_inst.wires(8'h02, 1'b0, 1'b1);
    wr(2'h1, ADDR_PORT_ORDER, 16'h0107, 16'h0, EXC_NONE);
    cyc(2);
    outs(1'b1, 3'h7);
    cyc(30);
    outs(1'b1, 3'h1);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b1);
    wr(2'h1, ADDR_MODE_CFG, 16'h0000, 16'h0, EXC_NONE);
    cyc(STOP_N + 5);
    $display("test reverse priority done");
    wr(2'h1, ADDR_PORT_ORDER, 16'h0000, 16'h0, EXC_NONE);
    wr(2'h1, ADDR_COMM_TMO, 16'h0002, 16'h0, EXC_NONE);
    wr(2'h1, ADDR_FS_BRIGHT, 16'h0005, 16'h0, EXC_NONE);
    wr(2'h1, ADDR_MODE_CFG, 16'h0020, 16'h0, EXC_NONE);
    cyc(20);
    check({15'h0, cl}, 16'h0001);
    outs(1'b1, 3'h5);
    acc(2'h1, FN_READ_WORDS, ADDR_STATUS, 8'h01, 16'h0, 16'h0, EXC_NONE, 16'h8305);
    wr(2'h1, ADDR_COMM_TMO, 16'h0000, 16'h0, EXC_NONE);
    cyc(2);
    check({15'h0, cl}, 16'h0000);
    outs(1'b0, 3'h0);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b0);
    cyc(3);
    outs(1'b1, 3'h5);
    wr(2'h1, ADDR_FS_BRIGHT, 16'h0000, 16'h0, EXC_NONE);
    cyc(2);
    outs(1'b0, 3'h0);
    rba_master_model_inst.wires(8'h00, 1'b0, 1'b1);
    wr(2'h1, ADDR_MODE_CFG, 16'h0000, 16'h0, EXC_NONE);
    $display("test fail safe done");
    for (int i = 0; i < 3; i++) begin
      rba_master_model_inst.sockop(0, 1'b1, 1'b0, g, rf);
      check({14'h0, g, rf}, (i < 2) ? 16'h0002 : 16'h0001);
    end
    rba_master_model_inst.sockop(0, 1'b0, 1'b1, g, rf);
    check({14'h0, g, rf}, 16'h0000);
    rba_master_model_inst.sockop(0, 1'b1, 1'b0, g, rf);
    check({14'h0, g, rf}, 16'h0002);
    rba_master_model_inst.sockop(1, 1'b1, 1'b0, g, rf);
    check({14'h0, g, rf}, 16'h0002);
    $display("test sockets done");
    wr(2'h1, ADDR_BAUD_SEL, 16'h0003, 16'h0, EXC_NONE);
    wr(2'h1, ADDR_BAUD_SEL, 16'h0004, 16'h0, EXC_BAD_VALUE);
    wr(2'h1, ADDR_SLAVE_ID, 16'h0000, 16'h0, EXC_BAD_VALUE);
    wr(2'h1, ADDR_SLAVE_ID, 16'h00FA, 16'h0, EXC_BAD_VALUE);
    wr(2'h1, ADDR_SLAVE_ID, 16'h00F9, 16'h0, EXC_NONE);
    wr(2'h2, ADDR_SLAVE_ID, 16'h0, 16'h0005, EXC_NONE);
    check({14'h0, baud_sel}, 16'h0002);
    check({8'h0, slave_id}, 16'h0001);
    do_reset(1'b0);
    check({14'h0, baud_sel}, 16'h0003);
    check({8'h0, slave_id}, 16'h0005);
    do_reset(1'b1);
    check({14'h0, baud_sel}, 16'h0002);
    check({8'h0, slave_id}, 16'h0001);
    $display("test serial settings done");
    results;
  end
endmodule
`default_nettype wire
